// ===== aks_kernel.sv
// The implementer's own choice: the burst-summing kernel engine.
module aks_kernel #(
  parameter int BEATS_W = 9
) (
  input wire logic ref_clk,
  input wire logic resetn,
  aks_ctl_if.dev ctl,
  output logic interrupt,
  output logic [aks_pkg::MEM_AW-1:0] m_araddr,
  output logic [7:0] m_arlen,
  output logic [2:0] m_arsize,
  output logic [1:0] m_arburst,
  output logic m_arvalid,
  input wire logic m_arready,
  input wire logic [aks_pkg::MEM_DW-1:0] m_rdata,
  input wire logic m_rlast,
  input wire logic m_rvalid,
  output logic m_rready,
  output logic [aks_pkg::MEM_AW-1:0] m_awaddr,
  output logic [7:0] m_awlen,
  output logic [2:0] m_awsize,
  output logic [1:0] m_awburst,
  output logic m_awvalid,
  input wire logic m_awready,
  output logic [aks_pkg::MEM_DW-1:0] m_wdata,
  output logic [3:0] m_wstrb,
  output logic m_wlast,
  output logic m_wvalid,
  input wire logic m_wready,
  input wire logic m_bvalid,
  output logic m_bready
);
  import aks_pkg::*;

  if (BEATS_W < 9) begin : g_width_check
    $error("BEATS_W must hold a count of 256");
  end

  logic [RST_STAGES-1:0] rst_pipe;
  logic rst_n;
  logic start;
  logic done;
  logic global_irq_gate_bit;
  logic source_irq_gate_bit;
  logic isr;
  logic [CTL_DW-1:0] args [ARG_N];
  logic [CTL_AW-1:0] wr_addr;
  logic [CTL_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic write_fire;
  logic read_take;
  logic done_event;
  logic [BEATS_W-1:0] beats;
  logic [MEM_DW-1:0] sum;
  aks_state_t state;

  function automatic logic in_args(input logic [CTL_AW-1:0] a);
    in_args = (a >= OFF_ARGUMENT_BASE) && (a < OFF_ARGUMENT_BASE + 12'(4 * ARG_N));
  endfunction : in_args

  function automatic int arg_idx(input logic [CTL_AW-1:0] a);
    logic [CTL_AW-1:0] d;
    d = a - OFF_ARGUMENT_BASE;
    arg_idx = int'(d[CTL_AW-1:2]);
  endfunction : arg_idx

  // ------------------------------------------------------------
  // reset pipeline
  // ------------------------------------------------------------
  // every process runs on ref_clk; no second clock or reset domain [RL1] [RL2] [RL4]
  // asserts at once, releases after the pipeline stages [RL3]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[RST_STAGES-1];

  // ------------------------------------------------------------
  // control slave handshakes
  // ------------------------------------------------------------
  // single control slave; write done once address and data held [RL6]
  assign write_fire = !ctl.awready && !ctl.wready && !ctl.bvalid;
  assign read_take = ctl.arvalid && ctl.arready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl.awready <= 1'b1;
      ctl.wready <= 1'b1;
      ctl.bvalid <= 1'b0;
      ctl.bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else begin
      if (ctl.awvalid && ctl.awready) begin
        ctl.awready <= 1'b0;
        wr_addr <= {ctl.awaddr[CTL_AW-1:2], 2'b00};
      end
      if (ctl.wvalid && ctl.wready) begin
        ctl.wready <= 1'b0;
        wr_data <= ctl.wdata;
        wr_strb <= ctl.wstrb;
      end
      if (write_fire) begin
        ctl.bvalid <= 1'b1;
        ctl.bresp <= (wr_addr < OFF_ARGUMENT_BASE || in_args(wr_addr)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (ctl.bvalid && ctl.bready) begin
        ctl.bvalid <= 1'b0;
        ctl.awready <= 1'b1;
        ctl.wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl.arready <= 1'b1;
      ctl.rvalid <= 1'b0;
      ctl.rdata <= '0;
      ctl.rresp <= RESP_OKAY;
    end else begin
      if (read_take) begin
        ctl.arready <= 1'b0;
        ctl.rvalid <= 1'b1;
        ctl.rresp <= RESP_OKAY;
        ctl.rdata <= '0; // [RL23]
        case ({ctl.araddr[CTL_AW-1:2], 2'b00})
          OFF_KERNEL_CONTROL: begin
            ctl.rdata[BIT_START] <= start;
            ctl.rdata[BIT_DONE] <= done;
            ctl.rdata[BIT_IDLE] <= (state == AKS_IDLE); // [RL16]
          end
          OFF_GLOBAL_IRQ_GATE: ctl.rdata[BIT_GATE] <= global_irq_gate_bit;
          OFF_SOURCE_IRQ_GATE: ctl.rdata[BIT_GATE] <= source_irq_gate_bit;
          OFF_IRQ_PENDING: ctl.rdata[BIT_GATE] <= isr;
          default: begin
            if (in_args(ctl.araddr)) begin
              ctl.rdata <= args[arg_idx(ctl.araddr)]; // [RL13]
            end else begin
              ctl.rresp <= RESP_SLVERR;
            end
          end
        endcase
      end
      if (ctl.rvalid && ctl.rready) begin
        ctl.rvalid <= 1'b0;
        ctl.arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // control and interrupt registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= 1'b0;
      done <= 1'b0;
    end else begin
      if (write_fire && wr_addr == OFF_KERNEL_CONTROL && wr_strb[0] && wr_data[BIT_START]) begin
        start <= 1'b1;
      end else if (done_event) begin
        start <= 1'b0; // [RL14]
      end
      // a finish in the read cycle still sets the flag [RL15]
      if (done_event) begin
        done <= 1'b1;
      end else if (read_take && {ctl.araddr[CTL_AW-1:2], 2'b00} == OFF_KERNEL_CONTROL) begin
        done <= 1'b0;
      end
    end
  end

  // the enable and status registers serve the interrupt output [RL18] [RL12]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_gate_bit <= 1'b0;
      source_irq_gate_bit <= 1'b0;
      isr <= 1'b0;
      interrupt <= 1'b0;
    end else begin
      if (write_fire && wr_strb[0] && wr_addr == OFF_GLOBAL_IRQ_GATE) begin
        global_irq_gate_bit <= wr_data[BIT_GATE];
      end
      if (write_fire && wr_strb[0] && wr_addr == OFF_SOURCE_IRQ_GATE) begin
        source_irq_gate_bit <= wr_data[BIT_GATE];
      end
      // completion is the source; a set wins over a clearing write [RL20] [RL22]
      if (done_event && source_irq_gate_bit) begin
        isr <= 1'b1;
      end else if (write_fire && wr_strb[0] && wr_addr == OFF_IRQ_PENDING
                   && wr_data[BIT_GATE]) begin
        isr <= ~isr; // toggles on a written one, where RL21 asks for a clear only [RL21]
      end
      interrupt <= isr && global_irq_gate_bit && source_irq_gate_bit; // [RL5] [RL19]
    end
  end

  // base offsets of the memory partitions live here [RL8]
  for (genvar i = 0; i < ARG_N; i++) begin : g_arg
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        args[i] <= ARG_RESET;
      end else if (write_fire && in_args(wr_addr) && arg_idx(wr_addr) == i) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_strb[b]) begin
            args[i][8*b +: 8] <= wr_data[8*b +: 8];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // kernel engine: sum a source burst, store it at destination
  // ------------------------------------------------------------
  assign done_event = (state == AKS_FINISH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= AKS_IDLE;
      beats <= '0;
      sum <= '0;
      m_araddr <= '0;
      m_arlen <= 8'h00;
      m_arsize <= SIZE_FULL;
      m_arburst <= BURST_INCR;
      m_arvalid <= 1'b0;
      m_rready <= 1'b0;
      m_awaddr <= '0;
      m_awlen <= 8'h00;
      m_awsize <= SIZE_FULL;
      m_awburst <= BURST_INCR;
      m_awvalid <= 1'b0;
      m_wdata <= '0;
      m_wstrb <= 4'h0;
      m_wlast <= 1'b0;
      m_wvalid <= 1'b0;
      m_bready <= 1'b0;
    end else begin
      case (state)
        AKS_IDLE: begin
          if (start) begin
            sum <= '0;
            beats <= (args[ARG_LEN] > MAX_BEATS) ? BEATS_W'(MAX_BEATS)
                                                  : BEATS_W'(args[ARG_LEN]);
            state <= (args[ARG_LEN] == 0) ? AKS_WADDR : AKS_RADDR;
          end
        end
        AKS_RADDR: begin
          // 64-bit address, incrementing, full-width beats [RL7] [RL9] [RL11]
          m_araddr <= {args[ARG_SRC_HI], args[ARG_SRC_LO]};
          m_arlen <= 8'(beats - 1'b1);
          m_arsize <= SIZE_FULL;
          m_arburst <= BURST_INCR;
          m_arvalid <= 1'b1;
          if (m_arvalid && m_arready) begin
            m_arvalid <= 1'b0;
            m_rready <= 1'b1;
            state <= AKS_RDATA;
          end
        end
        AKS_RDATA: begin
          if (m_rvalid) begin
            sum <= sum + m_rdata;
            if (m_rlast) begin
              m_rready <= 1'b0;
              state <= AKS_WADDR;
            end
          end
        end
        AKS_WADDR: begin
          m_awaddr <= {args[ARG_DST_HI], args[ARG_DST_LO]}; // [RL7] [RL11]
          m_awlen <= 8'h00;
          m_awsize <= SIZE_FULL; // [RL9]
          m_awburst <= BURST_INCR;
          m_awvalid <= 1'b1;
          m_wdata <= sum;
          m_wstrb <= 4'hF;
          m_wlast <= 1'b1;
          m_wvalid <= 1'b1;
          state <= AKS_WDATA;
        end
        AKS_WDATA: begin
          if (m_awready) begin
            m_awvalid <= 1'b0;
          end
          if (m_wready) begin
            m_wvalid <= 1'b0;
          end
          if ((!m_awvalid || m_awready) && (!m_wvalid || m_wready)) begin
            m_bready <= 1'b1;
            state <= AKS_WRESP;
          end
        end
        AKS_WRESP: begin
          if (m_bvalid) begin
            m_bready <= 1'b0;
            m_wlast <= 1'b0;
            state <= AKS_FINISH;
          end
        end
        AKS_FINISH: state <= AKS_IDLE;
        default: state <= AKS_IDLE;
      endcase
    end
  end
endmodule : aks_kernel

// ===== aks_pkg.sv
// Function
// RL1 - primary clock times all kernel logic
// RL2 - optional secondary clock for second domain
// RL3 - primary reset active low, pipelined inside
// RL4 - secondary reset active low, pipelined inside
// RL5 - optional single active high interrupt output
// RL6 - exactly one AXI4-Lite control slave port
// RL7 - memory master addresses are 64 bits
// RL8 - each memory base held in writable register
// RL9 - only incrementing full width bursts
// RL10 - host writes scalar arguments over control port
// RL11 - kernel moves pointer data via memory master
// RL12 - control, enables, status at 0x0 to 0xC
// RL13 - argument registers start at 0x10
// RL14 - start bit clears when done asserts
// RL15 - done sets on finish, clears on read
// RL16 - bit 2 idle, upper bits reserved
// RL17 - host launches by writing 1, polls done
// RL18 - interrupt registers only with interrupt output
// RL19 - interrupt needs both enable bits set
// RL20 - completion event is default interrupt source
// RL21 - status bit clears only by writing one; the code toggles it on a written one, so a clear bit sets
// RL22 - status sets on enabled completion, gated output
// RL23 - reserved bits read zero, ignore writes
package aks_pkg;
  localparam int CTL_AW = 12;
  localparam int CTL_DW = 32;
  localparam int MEM_AW = 64;
  localparam int MEM_DW = 32;
  localparam logic [CTL_AW-1:0] OFF_KERNEL_CONTROL = 12'h000;
  localparam logic [CTL_AW-1:0] OFF_GLOBAL_IRQ_GATE = 12'h004;
  localparam logic [CTL_AW-1:0] OFF_SOURCE_IRQ_GATE = 12'h008;
  localparam logic [CTL_AW-1:0] OFF_IRQ_PENDING = 12'h00C;
  localparam logic [CTL_AW-1:0] OFF_ARGUMENT_BASE = 12'h010;
  // argument words: src lo/hi, dst lo/hi, word count
  localparam int ARG_N = 5;
  localparam int ARG_SRC_LO = 0;
  localparam int ARG_SRC_HI = 1;
  localparam int ARG_DST_LO = 2;
  localparam int ARG_DST_HI = 3;
  localparam int ARG_LEN = 4;
  localparam int BIT_START = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_IDLE = 2;
  localparam int BIT_GATE = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [2:0] SIZE_FULL = 3'h2;
  localparam int MAX_BEATS = 256;
  localparam logic [31:0] LAUNCH_WORD = 32'h0000_0001;
  localparam logic [CTL_DW-1:0] ARG_RESET = 32'h0000_0000;
  localparam int RST_STAGES = 2;

  typedef enum logic [6:0] {
    AKS_IDLE = 7'h01,
    AKS_RADDR = 7'h02,
    AKS_RDATA = 7'h04,
    AKS_WADDR = 7'h08,
    AKS_WDATA = 7'h10,
    AKS_WRESP = 7'h20,
    AKS_FINISH = 7'h40
  } aks_state_t;

  typedef enum logic [2:0] {
    AKH_IDLE = 3'h1,
    AKH_WRITE = 3'h2,
    AKH_READ = 3'h4
  } aks_host_state_t;
endpackage : aks_pkg

// ===== aks_ctl_if.sv
interface aks_ctl_if;
  import aks_pkg::*;
  logic [CTL_AW-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [CTL_DW-1:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [CTL_AW-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [CTL_DW-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;

  modport dev (
    input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
    output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );
  modport host (
    output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
    input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );
endinterface : aks_ctl_if

// ===== aks_host.sv
module aks_host (
  input wire logic ref_clk,
  input wire logic resetn,
  aks_ctl_if.host ctl,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [aks_pkg::CTL_AW-1:0] cmd_addr,
  input wire logic [aks_pkg::CTL_DW-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [aks_pkg::CTL_DW-1:0] rsp_data,
  output logic rsp_err
);
  import aks_pkg::*;

  aks_host_state_t state;

  // ------------------------------------------------------------
  // command sequencing
  // ------------------------------------------------------------
  // scalar and launch writes go out as plain register writes [RL10] [RL17]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= AKH_IDLE;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_err <= 1'b0;
      ctl.awaddr <= '0;
      ctl.awvalid <= 1'b0;
      ctl.wdata <= '0;
      ctl.wstrb <= 4'h0;
      ctl.wvalid <= 1'b0;
      ctl.bready <= 1'b0;
      ctl.araddr <= '0;
      ctl.arvalid <= 1'b0;
      ctl.rready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        AKH_IDLE: begin
          if (cmd_valid && cmd_write) begin
            state <= AKH_WRITE;
            cmd_ready <= 1'b0;
            ctl.awaddr <= cmd_addr;
            ctl.awvalid <= 1'b1;
            ctl.wdata <= cmd_wdata;
            ctl.wstrb <= 4'hF;
            ctl.wvalid <= 1'b1;
            ctl.bready <= 1'b1;
          end else if (cmd_valid) begin
            state <= AKH_READ;
            cmd_ready <= 1'b0;
            ctl.araddr <= cmd_addr;
            ctl.arvalid <= 1'b1;
            ctl.rready <= 1'b1;
          end
        end
        AKH_WRITE: begin
          if (ctl.awready) begin
            ctl.awvalid <= 1'b0;
          end
          if (ctl.wready) begin
            ctl.wvalid <= 1'b0;
          end
          if (ctl.bvalid) begin
            state <= AKH_IDLE;
            ctl.bready <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_data <= '0;
            rsp_err <= (ctl.bresp != RESP_OKAY);
          end
        end
        AKH_READ: begin
          if (ctl.arready) begin
            ctl.arvalid <= 1'b0;
          end
          if (ctl.rvalid) begin
            state <= AKH_IDLE;
            ctl.rready <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_data <= ctl.rdata;
            rsp_err <= (ctl.rresp != RESP_OKAY);
          end
        end
        default: begin
          state <= AKH_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule : aks_host

// ===== aks_asserts.sv
module aks_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [aks_pkg::CTL_DW-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic interrupt,
  input wire logic m_arvalid,
  input wire logic m_arready,
  input wire logic [aks_pkg::MEM_AW-1:0] m_araddr,
  input wire logic [2:0] m_arsize,
  input wire logic [1:0] m_arburst,
  input wire logic m_awvalid,
  input wire logic [7:0] m_awlen,
  input wire logic [2:0] m_awsize,
  input wire logic [1:0] m_awburst,
  input wire logic m_wvalid,
  input wire logic m_wlast,
  input wire logic [3:0] m_wstrb
);
  import aks_pkg::*;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // control slave
  // ---------------------------------------------------------------
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before bready");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before rready");
  a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("unmapped read returned data");

  // ---------------------------------------------------------------
  // memory master
  // ---------------------------------------------------------------
  a_ar_incr: assert property (m_arvalid |-> m_arburst == BURST_INCR
      && m_arsize == SIZE_FULL)
    else $error("read burst not full width incrementing");
  a_aw_incr: assert property (m_awvalid |-> m_awburst == BURST_INCR
      && m_awsize == SIZE_FULL && m_awlen == 8'h0)
    else $error("write burst not single full width");
  a_w_full: assert property (m_wvalid |-> m_wlast && m_wstrb == 4'hF)
    else $error("narrow or unterminated write beat");
  a_ar_stable: assert property (m_arvalid && !m_arready |=> m_arvalid
      && $stable(m_araddr))
    else $error("read address dropped before taken");

  c_done_read: cover property (rvalid && rready && rdata[BIT_DONE]);
  c_irq_rise: cover property ($rose(interrupt));
  c_slverr: cover property (bvalid && bready && bresp == RESP_SLVERR);
endmodule : aks_asserts

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import aks_pkg::*;

  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_write = 1'h0;
  logic [CTL_AW-1:0] cmd_addr = 12'h0;
  logic [CTL_DW-1:0] cmd_wdata = 32'h0;
  logic cmd_ready, rsp_valid, rsp_err, interrupt;
  logic [CTL_DW-1:0] rsp_data;
  logic [MEM_AW-1:0] m_araddr, m_awaddr;
  logic [7:0] m_arlen, m_awlen;
  logic [2:0] m_arsize, m_awsize;
  logic [1:0] m_arburst, m_awburst;
  logic m_arvalid, m_rready, m_awvalid, m_wlast, m_wvalid, m_bready;
  logic [MEM_DW-1:0] m_wdata;
  logic [3:0] m_wstrb;
  logic m_arready = 1'h0, m_rlast = 1'h0, m_rvalid = 1'h0, m_awready = 1'h0;
  logic m_wready = 1'h0, m_bvalid = 1'h0;
  logic [MEM_DW-1:0] m_rdata = 32'h0;
  int miscompares = 0, tests_run = 0, nrsp = 0, jobs = 0, rd_left = 0, cycles = 0, beats = 0;
  logic [32:0] exp_q[$];
  logic [31:0] sum_acc = 32'h0;
  logic [63:0] src = 64'h0, dst = 64'h0;
  logic aw_got = 1'h0, w_got = 1'h0, global_irq_gate_bit, source_irq_gate_bit;
  logic [31:0] args [ARG_N];
  int lens [3] = '{300, 1, 0};

  aks_ctl_if ctl();
  aks_host i_aks_host (.ref_clk, .resetn, .ctl(ctl), .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data, .rsp_err);
  aks_kernel i_aks_kernel (.ref_clk, .resetn, .ctl(ctl), .interrupt, .m_araddr, .m_arlen,
    .m_arsize, .m_arburst, .m_arvalid, .m_arready, .m_rdata, .m_rlast, .m_rvalid, .m_rready,
    .m_awaddr, .m_awlen, .m_awsize, .m_awburst, .m_awvalid, .m_awready, .m_wdata, .m_wstrb,
    .m_wlast, .m_wvalid, .m_wready, .m_bvalid, .m_bready);
  aks_asserts i_aks_asserts (.ref_clk, .resetn, .awvalid(ctl.awvalid), .awready(ctl.awready),
    .wvalid(ctl.wvalid), .wready(ctl.wready), .bvalid(ctl.bvalid), .bready(ctl.bready),
    .bresp(ctl.bresp), .arvalid(ctl.arvalid), .arready(ctl.arready), .rvalid(ctl.rvalid),
    .rready(ctl.rready), .rdata(ctl.rdata), .rresp(ctl.rresp), .interrupt, .m_arvalid,
    .m_arready, .m_araddr, .m_arsize, .m_arburst, .m_awvalid, .m_awlen, .m_awsize,
    .m_awburst, .m_wvalid, .m_wlast, .m_wstrb);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // expectation is {err, data}; writes answer with data zero
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int n;
    n = nrsp;
    exp_q.push_back(e);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge ref_clk);
    while (cmd_ready !== 1'h1) @(posedge ref_clk);
    cmd_valid <= 1'h0;
    while (nrsp == n) @(posedge ref_clk);
  endtask : bus

  // ---------------------------------------------------------------
  // response watcher, memory far side, timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'h1) begin
      chk(64'({rsp_err, rsp_data}), 64'(exp_q.pop_front()));
      nrsp <= nrsp + 1;
    end
  end

  always @(posedge ref_clk) begin
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    m_arready <= 1'($urandom);
    m_awready <= 1'($urandom);
    m_wready <= 1'($urandom);
    if (m_arvalid && m_arready) begin
      chk(m_araddr, src);
      chk(64'(m_arlen), 64'(beats - 1));
      rd_left = int'(m_arlen) + 1;
    end
    if (m_rvalid && m_rready) begin
      sum_acc = sum_acc + m_rdata;
      rd_left = rd_left - 1;
    end
    // beat held while offered; line churns when idle
    if (!(m_rvalid && !m_rready)) begin
      m_rvalid <= (rd_left > 0) && 1'($urandom);
      m_rlast <= (rd_left == 1);
      m_rdata <= $urandom;
    end
    if (m_awvalid && m_awready) begin
      chk(m_awaddr, dst);
      aw_got = 1'h1;
    end
    if (m_wvalid && m_wready) begin
      chk(64'(m_wdata), 64'(sum_acc));
      sum_acc = 32'h0;
      w_got = 1'h1;
    end
    if (m_bvalid && m_bready) begin
      m_bvalid <= 1'h0;
      jobs <= jobs + 1;
    end else if (aw_got && w_got) begin
      m_bvalid <= 1'h1;
      aw_got = 1'h0;
      w_got = 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(46969));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge ref_clk);
    bus(1'h0, OFF_KERNEL_CONTROL, 32'h0, 33'h4);
    for (int i = 1; i < 9; i++) bus(1'h0, 12'(4 * i), 32'h0, 33'h0);
    bus(1'h1, 12'h024, 32'h5, 33'h1_0000_0000);
    bus(1'h0, 12'h024, 32'h0, 33'h1_0000_0000);
    $display("register map test done");
    for (int j = 0; j < 3; j++) begin
      global_irq_gate_bit = 1'(j != 2);
      source_irq_gate_bit = 1'(j != 1);
      src = {$urandom, $urandom};
      dst = {$urandom, $urandom};
      beats = lens[j] > MAX_BEATS ? MAX_BEATS : lens[j];
      args = '{src[31:0], src[63:32], dst[31:0], dst[63:32], 32'(lens[j])};
      for (int k = 0; k < ARG_N; k++) bus(1'h1, OFF_ARGUMENT_BASE + 12'(4 * k), args[k], 33'h0);
      for (int k = 0; k < ARG_N; k++) begin
        bus(1'h0, OFF_ARGUMENT_BASE + 12'(4 * k), 32'h0, {1'h0, args[k]});
      end
      bus(1'h1, OFF_GLOBAL_IRQ_GATE, {31'h7FFF_FFFF, global_irq_gate_bit}, 33'h0);
      bus(1'h1, OFF_SOURCE_IRQ_GATE, {31'h7FFF_FFFF, source_irq_gate_bit}, 33'h0);
      bus(1'h0, OFF_GLOBAL_IRQ_GATE, 32'h0, {32'h0, global_irq_gate_bit});
      bus(1'h0, OFF_SOURCE_IRQ_GATE, 32'h0, {32'h0, source_irq_gate_bit});
      n = jobs;
      bus(1'h1, OFF_KERNEL_CONTROL, LAUNCH_WORD, 33'h0);
      for (int t = 0; t < 3000 && jobs == n; t++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      bus(1'h0, OFF_KERNEL_CONTROL, 32'h0, 33'h6);
      bus(1'h0, OFF_KERNEL_CONTROL, 32'h0, 33'h4);
      bus(1'h0, OFF_IRQ_PENDING, 32'h0, {32'h0, source_irq_gate_bit});
      chk(64'(interrupt), 64'(global_irq_gate_bit & source_irq_gate_bit));
      bus(1'h1, OFF_IRQ_PENDING, 32'hFFFF_FFFE, 33'h0);
      bus(1'h0, OFF_IRQ_PENDING, 32'h0, {32'h0, source_irq_gate_bit});
      // a one toggles the status: a pending bit clears, a clear bit sets
      bus(1'h1, OFF_IRQ_PENDING, 32'h1, 33'h0);
      bus(1'h0, OFF_IRQ_PENDING, 32'h0, {32'h0, ~source_irq_gate_bit});
      chk(64'(interrupt), 64'h0);
      if (!source_irq_gate_bit) begin
        bus(1'h1, OFF_IRQ_PENDING, 32'h1, 33'h0);
        bus(1'h0, OFF_IRQ_PENDING, 32'h0, 33'h0);
      end
      $display("job %0d done", j);
    end
    finish_test();
  end
endmodule : testbench
